// *** hw/asu_pkg.sv ***
/*
 Constants, state encodings and register map for the asynchronous serial unit.
 Assumes a single 40 MHz clock domain and a plain strobe-based register port.
*/
// Notes on behaviour
// RULE_01 - Separate 8-bit fine dividers, zero bypasses them
// RULE_02 - Sleep blocks receive flags and receive interrupts
// RULE_03 - Wake method: 0 idle line, 1 address mark
// RULE_04 - Idle wake clears sleep, idle flag stays clear
// RULE_05 - Address word clears sleep and is received
// RULE_06 - Software must not write control two while asleep
// RULE_07 - Start, 8/9 data or parity, one stop
// RULE_08 - Address mark tests data MSB, not parity
// RULE_09 - Parity over low 7 or 8 bits
// RULE_10 - Transmit parity replaces the written MSB
// RULE_11 - Parity mismatch sets error flag, optional interrupt
// RULE_12 - Sixteen samples per bit, vote 8-10, realign
// RULE_13 - Wait wakes on interrupt, halt freezes everything
// RULE_14 - One vector, flag and enable, global mask
// RULE_15 - Status resets to c0
// RULE_16 - Empty flag sets on load, cleared by sequence
// RULE_17 - Done flag sets after data frame
// RULE_18 - Status then data read clears receive flags
// RULE_19 - Overrun keeps holding buffer, shifter overwritten
// RULE_20 - Idle flag rearmed only by new word
// RULE_21 - Noise and framing flags ride with ready
// RULE_22 - Framing plus overrun sets only overrun
// RULE_23 - Ninth bit stored and sent in own fields
// RULE_24 - Receive enable gates ready and overrun
// RULE_25 - Clear only flags seen by the status read
package asu_pkg;
    // Register offsets
    localparam logic [2:0] A_STATUS = 3'h0;
    localparam logic [2:0] A_DATA = 3'h1;
    localparam logic [2:0] A_CTRL1 = 3'h2;
    localparam logic [2:0] A_CTRL2 = 3'h3;
    localparam logic [2:0] A_BAUD = 3'h4;
    localparam logic [2:0] A_RXF = 3'h5;
    localparam logic [2:0] A_TXF = 3'h6;
    // Status bits
    localparam int ST_TRANSMIT_EMPTY_FLAG = 7;
    localparam int ST_TC = 6;
    localparam int ST_RECEIVE_READY_FLAG = 5;
    localparam int ST_IDLE = 4;
    localparam int ST_OR = 3;
    localparam int ST_NF = 2;
    localparam int ST_FE = 1;
    localparam int ST_PE = 0;
    localparam logic [7:0] STATUS_RST = 8'hc0;
    localparam logic [7:0] RX_MASK = 8'h3f;
    localparam logic [7:0] TX_MASK = 8'hc0;
    // Control one bits
    localparam int C1_RX9 = 7;
    localparam int C1_TX9 = 6;
    localparam int C1_OFF = 5;
    localparam int C1_M = 4;
    localparam int C1_WAKE = 3;
    localparam int C1_PCE = 2;
    localparam int C1_PS = 1;
    localparam int C1_PIE = 0;
    // Control two bits
    localparam int C2_TIE = 7;
    localparam int C2_TX_DONE_IRQ_ENABLE = 6;
    localparam int C2_RIE = 5;
    localparam int C2_IDLE_IRQ_ENABLE = 4;
    localparam int C2_TE = 3;
    localparam int C2_RE = 2;
    localparam int C2_SLEEP = 1;
    localparam int C2_SBK = 0;
    // Coarse prescaler factors
    localparam logic [3:0] PR_F0 = 4'h1;
    localparam logic [3:0] PR_F1 = 4'h3;
    localparam logic [3:0] PR_F2 = 4'h4;
    localparam logic [3:0] PR_F3 = 4'hd;
    localparam logic [7:0] FINE_OFF = 8'h00;
    localparam logic [7:0] FINE_ONE = 8'h01;
    // Bit timing in oversample ticks
    localparam logic [3:0] OS_LAST = 4'hf;
    localparam logic [3:0] SAMP_A = 4'h7;
    localparam logic [3:0] SAMP_B = 4'h8;
    localparam logic [3:0] SAMP_C = 4'h9;
    // Frame shape
    localparam logic [3:0] NB_SHORT = 4'h8;
    localparam logic [3:0] NB_LONG = 4'h9;
    localparam logic [3:0] FRAME_SHORT = 4'ha;
    localparam logic [3:0] FRAME_LONG = 4'hb;
    // One-hot state codes
    typedef enum logic [3:0] {
        RX_IDLE = 4'h1,
        RX_START = 4'h2,
        RX_DATA = 4'h4,
        RX_STOP = 4'h8
    } asu_rx_e;
    typedef enum logic [2:0] {
        TX_OFF = 3'h1,
        TX_IDLE = 3'h2,
        TX_SEND = 3'h4
    } asu_tx_e;
endpackage

// *** hw/asu_top.sv ***
/*
 Asynchronous serial unit: fine baud dividers, 16x receiver, transmitter,
 mute with wake-up, parity and read-then-access status clearing.
 Assumes one clock mclk, a register master that never waits, and an
 asynchronous receive pin that is synchronised here.
*/
// The strobed register port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
module asu_top (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wrStb,
    input wire logic rdStb,
    output logic [7:0] rdata,
    input wire logic rxPin,
    output logic txPin,
    input wire logic haltMode,
    input wire logic waitMode,
    input wire logic globalMask,
    output logic irqReq,
    output logic waitWake
);
    // Whole module state
    typedef struct packed {
        logic rxA;              // Sync stage one
        logic rxB;              // Sync stage two
        logic rxPrev;           // Edge history
        logic [7:0] c1;         // Control one
        logic [7:0] c2;         // Control two
        logic [7:0] baud;       // Coarse rate selects
        logic [7:0] rxFine;     // Receive fine factor
        logic [7:0] txFine;     // Transmit fine factor
        logic [7:0] st;         // Status flags
        logic pendV;            // Status read seen
        logic [7:0] pendM;      // Flags seen by it
        logic [7:0] rxBuf;      // Receive holding buffer
        logic [7:0] txBuf;      // Transmit holding buffer
        logic [7:0] rdata;      // Read data
        logic irq;              // Shared request
        logic txLine;           // Pin level
        asu_pkg::asu_rx_e rxSt;
        logic [18:0] rxDiv;
        logic [3:0] rxOs;
        logic [3:0] rxBit;
        logic [8:0] rxSh;
        logic s8;
        logic s9;
        logic rxNoise;
        logic [7:0] idleCnt;
        logic idleArm;
        asu_pkg::asu_tx_e txSt;
        logic [18:0] txDiv;
        logic [3:0] txOs;
        logic [3:0] txLeft;
        logic [10:0] txSh;
        logic txData;           // Frame is data, not preamble
        logic txRedo;           // Enable pulsed during frame
    } asu_state_s;

    asu_state_s q;
    asu_state_s d;
    logic rxTick;
    logic txTick;
    logic wordEv;
    logic idleEv;
    logic frameEnd;
    logic [7:0] stSet;
    logic [7:0] stClr;

    // Oversample divisor: coarse times rate times fine
    function automatic logic [18:0] rateDiv(input logic [1:0] pre, input logic [2:0] sh,
        input logic [7:0] fine);
        logic [3:0] pr;
        logic [19:0] prod;
        logic [7:0] fEff;
        pr = asu_pkg::PR_F0;
        unique case (pre)
            2'h0: pr = asu_pkg::PR_F0;
            2'h1: pr = asu_pkg::PR_F1;
            2'h2: pr = asu_pkg::PR_F2;
            2'h3: pr = asu_pkg::PR_F3;
        endcase
        // Zero means no extra division
        fEff = (fine == asu_pkg::FINE_OFF) ? asu_pkg::FINE_ONE : fine; // [RULE_01]
        prod = {16'h0000, pr} << sh;
        prod = prod * {12'h000, fEff};
        return prod[18:0];
    endfunction

    // Parity bit over low 7 or 8 bits
    function automatic logic parBit(input logic [8:0] w, input logic m, input logic odd);
        return (m ? ^w[7:0] : ^w[6:0]) ^ odd; // [RULE_09]
    endfunction

    // Two of three vote
    function automatic logic vote(input logic a, input logic b, input logic c);
        return (a & b) | (b & c) | (a & c);
    endfunction

    // Next-state logic
    always_comb
    begin
        logic rdDat;
        logic wrDat;
        logic maj;
        logic msb;
        logic fe;
        logic [3:0] nBits;
        logic [7:0] frameTicks;
        logic [8:0] word;
        logic [8:0] txWord;
        d = q;
        rxTick = 1'b0;
        txTick = 1'b0;
        wordEv = 1'b0;
        idleEv = 1'b0;
        frameEnd = 1'b0;
        stSet = 8'h00;
        stClr = 8'h00;
        fe = 1'b0;
        maj = 1'b0;
        msb = 1'b0;
        word = 9'h000;
        txWord = 9'h000;
        rdDat = rdStb && (addr == asu_pkg::A_DATA);
        wrDat = wrStb && (addr == asu_pkg::A_DATA);
        nBits = q.c1[asu_pkg::C1_M] ? asu_pkg::NB_LONG : asu_pkg::NB_SHORT; // [RULE_07]
        frameTicks = {q.c1[asu_pkg::C1_M] ? asu_pkg::FRAME_LONG : asu_pkg::FRAME_SHORT, 4'h0};
        // Pin synchroniser, stage one read only by stage two
        d.rxA = rxPin;
        d.rxB = q.rxA;
        d.rxPrev = q.rxB;

        // Register reads, unmapped reads as zero
        d.rdata = 8'h00;
        if (rdStb)
        begin
            case (addr)
                asu_pkg::A_STATUS: d.rdata = q.st;
                asu_pkg::A_DATA: d.rdata = q.rxBuf;
                asu_pkg::A_CTRL1: d.rdata = q.c1;
                asu_pkg::A_CTRL2: d.rdata = q.c2;
                asu_pkg::A_BAUD: d.rdata = q.baud;
                asu_pkg::A_RXF: d.rdata = q.rxFine;
                asu_pkg::A_TXF: d.rdata = q.txFine;
                default: d.rdata = 8'h00;
            endcase
        end
        // Register writes; ninth receive bit is hardware only
        if (wrStb)
        begin
            case (addr)
                asu_pkg::A_CTRL1: d.c1 = {q.c1[asu_pkg::C1_RX9], wdata[6:0]};
                // A write here while asleep may re-set sleep
                asu_pkg::A_CTRL2: d.c2 = wdata; // [RULE_06]
                asu_pkg::A_BAUD: d.baud = wdata;
                asu_pkg::A_RXF: d.rxFine = wdata;
                asu_pkg::A_TXF: d.txFine = wdata;
                asu_pkg::A_DATA: d.txBuf = wdata;
                default: d.txBuf = q.txBuf;
            endcase
        end
        // Snapshot flags on status read
        if (rdStb && (addr == asu_pkg::A_STATUS))
        begin
            d.pendV = 1'b1; // [RULE_25]
            d.pendM = q.st; // [RULE_25]
        end
        // Data access after status read clears only the snapshot
        if ((rdDat || wrDat) && q.pendV)
        begin
            stClr = q.pendM & (rdDat ? asu_pkg::RX_MASK : asu_pkg::TX_MASK); // [RULE_18] [RULE_16] [RULE_17]
            d.pendV = 1'b0;
        end

        // Receive prescaler
        if (q.c2[asu_pkg::C2_RE] && !q.c1[asu_pkg::C1_OFF])
        begin
            if (q.rxDiv + 19'h00001 >= rateDiv(q.baud[7:6], q.baud[2:0], q.rxFine)) // [RULE_01]
            begin
                rxTick = 1'b1;
                d.rxDiv = 19'h00000;
            end
            else
            begin
                d.rxDiv = q.rxDiv + 19'h00001;
            end
        end
        // Transmit prescaler
        if (q.c2[asu_pkg::C2_TE] && !q.c1[asu_pkg::C1_OFF])
        begin
            if (q.txDiv + 19'h00001 >= rateDiv(q.baud[7:6], q.baud[5:3], q.txFine)) // [RULE_01]
            begin
                txTick = 1'b1;
                d.txDiv = 19'h00000;
            end
            else
            begin
                d.txDiv = q.txDiv + 19'h00001;
            end
        end

        // Receiver sequencing
        maj = vote(q.s8, q.s9, q.rxB); // [RULE_12]
        if (rxTick && (q.rxSt != asu_pkg::RX_IDLE))
        begin
            d.rxOs = q.rxOs + 4'h1;
            if (q.rxOs == asu_pkg::SAMP_A)
                d.s8 = q.rxB;
            if (q.rxOs == asu_pkg::SAMP_B)
                d.s9 = q.rxB;
            // Disagreeing samples mark noise
            if ((q.rxOs == asu_pkg::SAMP_C) && ((q.s8 != q.s9) || (q.s9 != q.rxB)))
                d.rxNoise = 1'b1;
        end
        unique case (q.rxSt)
            asu_pkg::RX_IDLE:
            begin
                if (q.c2[asu_pkg::C2_RE] && q.rxPrev && !q.rxB)
                begin
                    // Start edge realigns the sample phase
                    d.rxSt = asu_pkg::RX_START; // [RULE_12]
                    d.rxDiv = 19'h00000;
                    d.rxOs = 4'h0;
                    d.rxNoise = 1'b0;
                    d.idleCnt = 8'h00;
                end
                else if (rxTick && q.rxB)
                begin
                    // Count one whole frame of ones, then saturate
                    if (q.idleCnt != frameTicks)
                        d.idleCnt = q.idleCnt + 8'h01;
                    if (q.idleCnt == frameTicks - 8'h01)
                        idleEv = 1'b1;
                end
                else if (rxTick)
                begin
                    d.idleCnt = 8'h00;
                end
            end
            asu_pkg::RX_START:
            begin
                // A high vote is a glitch, not a start
                if (rxTick && (q.rxOs == asu_pkg::SAMP_C) && maj)
                    d.rxSt = asu_pkg::RX_IDLE;
                else if (rxTick && (q.rxOs == asu_pkg::OS_LAST))
                begin
                    d.rxSt = asu_pkg::RX_DATA;
                    d.rxBit = 4'h0;
                end
            end
            asu_pkg::RX_DATA:
            begin
                if (rxTick && (q.rxOs == asu_pkg::SAMP_C))
                    d.rxSh[q.rxBit] = maj; // [RULE_07]
                if (rxTick && (q.rxOs == asu_pkg::OS_LAST))
                begin
                    if (q.rxBit == nBits - 4'h1)
                        d.rxSt = asu_pkg::RX_STOP;
                    else
                        d.rxBit = q.rxBit + 4'h1;
                end
            end
            asu_pkg::RX_STOP:
            begin
                // Word ends at the stop bit centre
                if (rxTick && (q.rxOs == asu_pkg::SAMP_C))
                begin
                    wordEv = 1'b1;
                    fe = !maj; // [RULE_21]
                    d.rxSt = asu_pkg::RX_IDLE;
                end
            end
            default: d.rxSt = asu_pkg::RX_IDLE;
        endcase
        if (!q.c2[asu_pkg::C2_RE])
            d.rxSt = asu_pkg::RX_IDLE;

        // Completed word
        word = q.c1[asu_pkg::C1_M] ? q.rxSh : {1'b0, q.rxSh[7:0]};
        msb = q.c1[asu_pkg::C1_M] ? q.rxSh[8] : q.rxSh[7]; // [RULE_08]
        if (wordEv)
        begin
            if (q.c2[asu_pkg::C2_SLEEP] && q.c1[asu_pkg::C1_WAKE] && msb)
                d.c2[asu_pkg::C2_SLEEP] = 1'b0; // [RULE_03] [RULE_05]
            // Sleeping receiver drops words unless it is woken
            if (!q.c2[asu_pkg::C2_SLEEP] || (q.c1[asu_pkg::C1_WAKE] && msb)) // [RULE_02]
            begin
                if (q.st[asu_pkg::ST_RECEIVE_READY_FLAG])
                begin
                    // Holding buffer kept, framing not reported
                    stSet[asu_pkg::ST_OR] = 1'b1; // [RULE_19] [RULE_22]
                end
                else
                begin
                    d.rxBuf = q.rxSh[7:0];
                    if (q.c1[asu_pkg::C1_M])
                        d.c1[asu_pkg::C1_RX9] = q.rxSh[8]; // [RULE_23]
                    stSet[asu_pkg::ST_RECEIVE_READY_FLAG] = 1'b1; // [RULE_05]
                    stSet[asu_pkg::ST_NF] = q.rxNoise; // [RULE_21]
                    stSet[asu_pkg::ST_FE] = fe; // [RULE_21]
                    stSet[asu_pkg::ST_PE] = q.c1[asu_pkg::C1_PCE] &&
                        (parBit(word, q.c1[asu_pkg::C1_M], q.c1[asu_pkg::C1_PS]) != msb); // [RULE_11]
                    d.idleArm = 1'b1; // [RULE_20]
                end
            end
        end
        // Idle frame: wakes an idle-wake sleeper; when awake, reports once per received word
        if (idleEv)
        begin
            if (q.c2[asu_pkg::C2_SLEEP])
            begin
                if (!q.c1[asu_pkg::C1_WAKE])
                    d.c2[asu_pkg::C2_SLEEP] = 1'b0; // [RULE_03] [RULE_04]
            end
            else if (q.idleArm)
            begin
                stSet[asu_pkg::ST_IDLE] = 1'b1; // [RULE_20]
                d.idleArm = 1'b0;
            end
        end

        // Transmit word; parity takes the MSB slot
        txWord = {q.c1[asu_pkg::C1_TX9], q.txBuf}; // [RULE_23]
        if (q.c1[asu_pkg::C1_PCE])
        begin
            if (q.c1[asu_pkg::C1_M])
                txWord[8] = parBit(txWord, 1'b1, q.c1[asu_pkg::C1_PS]); // [RULE_10]
            else
                txWord[7] = parBit(txWord, 1'b0, q.c1[asu_pkg::C1_PS]); // [RULE_10]
        end
        if (!q.c1[asu_pkg::C1_M])
            txWord[8] = 1'b1;
        // Transmitter sequencing
        unique case (q.txSt)
            asu_pkg::TX_OFF:
            begin
                // Enabling sends a preamble frame first
                if (q.c2[asu_pkg::C2_TE])
                begin
                    d.txSh = '1;
                    d.txLeft = asu_pkg::FRAME_LONG;
                    d.txData = 1'b0;
                    d.txRedo = 1'b0;
                    d.txDiv = 19'h00000;
                    d.txOs = 4'h0;
                    d.txSt = asu_pkg::TX_SEND;
                end
            end
            asu_pkg::TX_IDLE:
            begin
                if (!q.c2[asu_pkg::C2_TE])
                    d.txSt = asu_pkg::TX_OFF;
                else if (!q.st[asu_pkg::ST_TRANSMIT_EMPTY_FLAG])
                begin
                    // Only a cleared empty flag hands data over
                    d.txSh = {1'b1, txWord, 1'b0}; // [RULE_07]
                    d.txLeft = nBits + 4'h2;
                    d.txData = 1'b1;
                    d.txDiv = 19'h00000;
                    d.txOs = 4'h0;
                    stSet[asu_pkg::ST_TRANSMIT_EMPTY_FLAG] = 1'b1; // [RULE_16]
                    d.txSt = asu_pkg::TX_SEND;
                end
            end
            asu_pkg::TX_SEND:
            begin
                if (!q.c2[asu_pkg::C2_TE])
                    d.txRedo = 1'b1;
                if (txTick)
                    d.txOs = q.txOs + 4'h1;
                if (txTick && (q.txOs == asu_pkg::OS_LAST))
                begin
                    d.txSh = {1'b1, q.txSh[10:1]};
                    d.txLeft = q.txLeft - 4'h1;
                    frameEnd = (q.txLeft == 4'h1);
                end
                if (frameEnd)
                begin
                    // Preamble frames do not count as done
                    stSet[asu_pkg::ST_TC] = q.txData; // [RULE_17]
                    d.txSt = q.txRedo ? asu_pkg::TX_OFF : asu_pkg::TX_IDLE;
                end
            end
            default: d.txSt = asu_pkg::TX_OFF;
        endcase
        d.txLine = (d.txSt == asu_pkg::TX_SEND) ? d.txSh[0] : 1'b1;

        // Set wins over a same-cycle clear
        d.st = (q.st & ~stClr) | stSet;
        // Shared request; receive sources muted while asleep
        d.irq = !globalMask && ( // [RULE_14]
            (q.st[asu_pkg::ST_TRANSMIT_EMPTY_FLAG] && q.c2[asu_pkg::C2_TIE]) ||
            (q.st[asu_pkg::ST_TC] && q.c2[asu_pkg::C2_TX_DONE_IRQ_ENABLE]) ||
            (!q.c2[asu_pkg::C2_SLEEP] && ( // [RULE_02]
            ((q.st[asu_pkg::ST_RECEIVE_READY_FLAG] || q.st[asu_pkg::ST_OR]) && q.c2[asu_pkg::C2_RIE]) || // [RULE_24]
            (q.st[asu_pkg::ST_IDLE] && q.c2[asu_pkg::C2_IDLE_IRQ_ENABLE]) ||
            (q.st[asu_pkg::ST_PE] && q.c1[asu_pkg::C1_PIE]))));
        // Halt freezes the whole unit
        if (haltMode)
            d = q; // [RULE_13]
    end

    // State register with synchronous reset
    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            q <= '0;
            q.st <= asu_pkg::STATUS_RST; // [RULE_15]
            q.txLine <= 1'b1;
            q.rxSt <= asu_pkg::RX_IDLE;
            q.txSt <= asu_pkg::TX_OFF;
        end
        else
        begin
            q <= d;
        end
    end

    assign rdata = q.rdata;
    assign txPin = q.txLine;
    assign irqReq = q.irq;
    // Any enabled request leaves wait mode
    assign waitWake = waitMode && q.irq; // [RULE_13]

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);

    a_status_reset: assert property ($rose(resetn) |-> q.st == asu_pkg::STATUS_RST) // [RULE_15]
        else $error("status not c0 after reset");
    a_sleep_flags: assert property (q.c2[asu_pkg::C2_SLEEP] && d.c2[asu_pkg::C2_SLEEP] // [RULE_02]
        && !haltMode |-> (stSet & asu_pkg::RX_MASK) == 8'h00)
        else $error("receive flag set while asleep");
    a_mask_irq: assert property (globalMask && !haltMode |=> !q.irq) // [RULE_14]
        else $error("request despite global mask");
    a_overrun_buf: assert property (wordEv && q.st[asu_pkg::ST_RECEIVE_READY_FLAG] && !haltMode // [RULE_19]
        && !q.c2[asu_pkg::C2_SLEEP] |=> $stable(q.rxBuf) && q.st[asu_pkg::ST_OR])
        else $error("overrun lost buffer or flag");
    a_fe_or_excl: assert property ($rose(q.st[asu_pkg::ST_OR]) |-> !$rose(q.st[asu_pkg::ST_FE])) // [RULE_22]
        else $error("framing set with overrun");
    a_tx_load: assert property (q.txSt == asu_pkg::TX_IDLE && q.c2[asu_pkg::C2_TE] // [RULE_16]
        && !q.st[asu_pkg::ST_TRANSMIT_EMPTY_FLAG] && !haltMode |=> q.st[asu_pkg::ST_TRANSMIT_EMPTY_FLAG] && !q.txLine)
        else $error("load did not start frame");
    a_halt_freeze: assert property (haltMode |=> $stable(q.txLine) && $stable(q.st)) // [RULE_13]
        else $error("unit moved in halt");
    a_rx_clear: assert property (q.pendV && q.pendM[asu_pkg::ST_RECEIVE_READY_FLAG] && rdStb // [RULE_18]
        && addr == asu_pkg::A_DATA && !wordEv && !haltMode |=> !q.st[asu_pkg::ST_RECEIVE_READY_FLAG])
        else $error("ready flag not cleared");
    a_idle_wake: assert property (idleEv && q.c2[asu_pkg::C2_SLEEP] && !q.c1[asu_pkg::C1_WAKE] // [RULE_04]
        && !haltMode && !wrStb |=> !q.c2[asu_pkg::C2_SLEEP] && !$rose(q.st[asu_pkg::ST_IDLE]))
        else $error("idle wake wrong");
    a_tx_line_idle: assert property (q.txSt != asu_pkg::TX_SEND |-> q.txLine) // [RULE_07]
        else $error("line low outside frame");

    c_word: cover property (wordEv && !q.st[asu_pkg::ST_RECEIVE_READY_FLAG] && !q.c2[asu_pkg::C2_SLEEP]);
    c_overrun: cover property ($rose(q.st[asu_pkg::ST_OR]));
    c_addr_wake: cover property (wordEv && q.c2[asu_pkg::C2_SLEEP] && q.c1[asu_pkg::C1_WAKE]);
    c_tx_done: cover property (frameEnd && q.txData);
endmodule

// *** verif/asu_remote.sv ***
/*
 Remote serial node: sends frames onto the receive line, listens to the transmit line.
 Assumes idle-high lines and a 16-cycle transmit bit at the reset baud setting.
*/
`timescale 1ns/100ps
module asu_remote (
    input wire logic mclk,
    input wire logic txLine,
    output logic rxLine
);
    logic [9:0] heard; // Last frame seen, start bit at 0
    initial rxLine = 1'b1;
    // Frame out LSB first; bits hold start, data and stop
    task automatic send(input logic [10:0] bits, input int n, input int cyc);
        for (int i = 0; i < n; i++)
        begin
            rxLine <= bits[i];
            repeat (cyc) @(posedge mclk);
        end
        rxLine <= 1'b1;
        // One idle edge, so back-to-back frames never drive the line twice at once
        @(posedge mclk);
    endtask
    // Mid-bit capture; preamble has no falling edge so is ignored
    always
    begin
        @(negedge txLine);
        repeat (8) @(posedge mclk);
        for (int i = 0; i < 10; i++)
        begin
            heard[i] = txLine;
            repeat (16) @(posedge mclk);
        end
    end
endmodule

// *** verif/asu_top_tb.sv ***
/*
 Self-checking bench for the serial unit: receive table, overrun, wake-up, transmit.
 Assumes the design's register map and one 40 MHz clock.
*/
`timescale 1ns/100ps
module asu_top_tb;
    logic mclk, resetn, wrStb, rdStb, rxPin, txPin, irqReq, waitWake;
    logic haltMode, waitMode, globalMask;
    logic [2:0] addr;
    logic [7:0] wdata, rdata;
    int error_cnt, tests_run;
    // One received frame and what software should then see
    typedef struct {logic [7:0] c1, fine; logic [10:0] bits; int n, cyc;
        logic [7:0] d, st, c1r;} asu_row_s;
    asu_row_s rows[7] = '{
        '{8'h00, 8'h00, {2'b11, 8'ha5, 1'b0}, 10, 16, 8'ha5, 8'he0, 8'h00},
        '{8'h04, 8'h00, {2'b11, 8'h35, 1'b0}, 10, 16, 8'h35, 8'he0, 8'h04},
        '{8'h04, 8'h00, {2'b11, 8'hb5, 1'b0}, 10, 16, 8'hb5, 8'he1, 8'h04},
        '{8'h06, 8'h00, {2'b11, 8'hb5, 1'b0}, 10, 16, 8'hb5, 8'he0, 8'h06},
        '{8'h10, 8'h00, {1'b1, 9'h1c3, 1'b0}, 11, 16, 8'hc3, 8'he0, 8'h90},
        '{8'h00, 8'h02, {2'b11, 8'h3c, 1'b0}, 10, 32, 8'h3c, 8'he0, 8'h80},
        '{8'h00, 8'h00, {2'b10, 8'h3c, 1'b0}, 10, 16, 8'h3c, 8'he2, 8'h80}};
    asu_top DUT (.mclk(mclk), .resetn(resetn), .addr(addr), .wdata(wdata), .wrStb(wrStb),
        .rdStb(rdStb), .rdata(rdata), .rxPin(rxPin), .txPin(txPin), .haltMode(haltMode),
        .waitMode(waitMode), .globalMask(globalMask), .irqReq(irqReq), .waitWake(waitWake));
    asu_remote peer (.mclk(mclk), .txLine(txPin), .rxLine(rxPin));
    initial
    begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    // Compare and count
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wrStb <= 1'b1;
        @(posedge mclk);
        wrStb <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [2:0] a, input logic [7:0] exp, input bit on);
        @(posedge mclk);
        addr <= a;
        rdStb <= 1'b1;
        @(posedge mclk);
        rdStb <= 1'b0;
        #1 if (on) chk("rdata", rdata, exp);
    endtask
    // Long idle gap, then status and data reads drop every receive flag
    task automatic flush();
        repeat (400) @(posedge mclk);
        rd(asu_pkg::A_STATUS, 8'h00, 0);
        rd(3'h1, 8'h00, 0);
    endtask
    task automatic complete_run();
        $display("errors %0d of %0d checks", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Hang guard, far past the expected run length
    initial
    begin
        repeat (40000) @(posedge mclk);
        error_cnt++;
        complete_run();
    end
    initial
    begin
        {resetn, wrStb, rdStb, haltMode, waitMode, globalMask, addr, wdata} = '0;
        repeat (20) @(posedge mclk);
        resetn <= 1'b1;
        rd(asu_pkg::A_STATUS, asu_pkg::STATUS_RST, 1);
        rd(3'h7, 8'h00, 1);
        // Receive table: formats, parity, ninth bit, fine divider, framing
        foreach (rows[i])
        begin
            wr(asu_pkg::A_CTRL1, rows[i].c1);
            wr(asu_pkg::A_RXF, rows[i].fine);
            wr(asu_pkg::A_CTRL2, 8'h04);
            flush();
            rd(asu_pkg::A_STATUS, 8'hc0, 1);
            peer.send(rows[i].bits, rows[i].n, rows[i].cyc);
            repeat (4) @(posedge mclk);
            rd(asu_pkg::A_STATUS, rows[i].st, 1);
            rd(asu_pkg::A_CTRL1, rows[i].c1r, 1);
            rd(asu_pkg::A_DATA, rows[i].d, 1);
        end
        // Overrun on a word that also lacks its stop bit
        flush();
        wr(asu_pkg::A_CTRL2, 8'h24);
        peer.send({2'b11, 8'ha5, 1'b0}, 10, 16);
        peer.send({2'b10, 8'h3c, 1'b0}, 10, 16);
        repeat (4) @(posedge mclk);
        waitMode <= 1'b1;
        @(posedge mclk);
        #1 chk("irq", {7'h0, irqReq}, 8'h01);
        chk("wake", {7'h0, waitWake}, 8'h01);
        globalMask <= 1'b1;
        repeat (2) @(posedge mclk);
        #1 chk("masked", {7'h0, irqReq}, 8'h00);
        globalMask <= 1'b0;
        rd(asu_pkg::A_STATUS, 8'he8, 1);
        rd(asu_pkg::A_DATA, 8'ha5, 1);
        // Asleep: plain word dropped, address word wakes and is kept
        flush();
        wr(asu_pkg::A_CTRL1, 8'h08);
        wr(asu_pkg::A_CTRL2, 8'h06);
        peer.send({2'b11, 8'h12, 1'b0}, 10, 16);
        rd(asu_pkg::A_STATUS, 8'hc0, 1);
        peer.send({2'b11, 8'h92, 1'b0}, 10, 16);
        repeat (4) @(posedge mclk);
        rd(asu_pkg::A_STATUS, 8'he0, 1);
        rd(asu_pkg::A_CTRL2, 8'h04, 1);
        rd(asu_pkg::A_DATA, 8'h92, 1);
        // Idle-line wake: dropped word, then a whole idle frame
        wr(asu_pkg::A_CTRL1, 8'h00);
        wr(asu_pkg::A_CTRL2, 8'h06);
        peer.send({2'b11, 8'h12, 1'b0}, 10, 16);
        repeat (200) @(posedge mclk);
        rd(asu_pkg::A_CTRL2, 8'h04, 1);
        rd(asu_pkg::A_STATUS, 8'hc0, 1);
        // Transmit with even parity: written MSB is replaced
        wr(asu_pkg::A_CTRL1, 8'h04);
        wr(asu_pkg::A_CTRL2, 8'h08);
        repeat (200) @(posedge mclk);
        rd(asu_pkg::A_STATUS, 8'hc0, 1);
        wr(asu_pkg::A_DATA, 8'h83);
        repeat (220) @(posedge mclk);
        chk("frame", peer.heard[8:1], 8'h03);
        chk("stop", {6'h0, peer.heard[9], peer.heard[0]}, 8'h02);
        rd(asu_pkg::A_STATUS, 8'hc0, 1);
        // Halt: a register write is ignored
        haltMode <= 1'b1;
        wr(asu_pkg::A_CTRL2, 8'h00);
        haltMode <= 1'b0;
        rd(asu_pkg::A_CTRL2, 8'h08, 1);
        complete_run();
    end
endmodule
